// >>> hw/dtc_defs.svh
/*
 * Constants of the driver calibration and termination block: bus offsets,
 * mode register fields, control fields, reset values and timing counts.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// Bus register offsets
`define DTC_OFS_CTRL      12'h000
`define DTC_OFS_STAT      12'h004
`define DTC_OFS_EMR       12'h008
`define DTC_OFS_MR        12'h00C

// Control register fields and reset value
`define DTC_CTRL_ORG_LSB  0
`define DTC_CTRL_DEF_LSB  2
`define DTC_CTRL_RST      32'h0000_0020

// Extended mode register fields
`define DTC_EMR_RTT_LO    2
`define DTC_EMR_AL_LSB    3
`define DTC_EMR_RTT_HI    6
`define DTC_EMR_CAL_LSB   7
`define DTC_EMR_NDQS      10
`define DTC_EMR_RDQS      11

// Base mode register fields
`define DTC_MR_CL_LSB     4
`define DTC_MR_SLOWPD     12

// Calibration field codes
`define DTC_CAL_EXIT      3'h0
`define DTC_CAL_DRV1      3'h1
`define DTC_CAL_DRV0      3'h2
`define DTC_CAL_ADJ       3'h4
`define DTC_CAL_DEF       3'h7

// Adjust code length in bit times
`define DTC_ADJ_LEN       3'h4

// Timing: clock period and driver on/off delay
`define DTC_CLK_NS        50
`define DTC_T_OIT_NS      12
`define DTC_OIT_RAW       ((`DTC_T_OIT_NS + `DTC_CLK_NS - 1) / `DTC_CLK_NS)
`define DTC_OIT_CYC       ((`DTC_OIT_RAW < 1) ? 1 : `DTC_OIT_RAW)

`endif

// >>> hw/dtc_pkg.sv
/*
 * Types of the driver calibration and termination block.
 * Assumes no other package.
 */
package dtc_pkg;

    // Calibration mode, Gray coded along entry and exit
    typedef enum logic [1:0] {
        DTC_CAL_OFF = 2'b00,
        DTC_CAL_HI  = 2'b01,
        DTC_CAL_LO  = 2'b11,
        DTC_CAL_ADJ = 2'b10
    } dtc_cal_e;

    // Device organisation
    typedef enum logic [1:0] {
        DTC_ORG_X4  = 2'b00,
        DTC_ORG_X8  = 2'b01,
        DTC_ORG_X16 = 2'b10
    } dtc_org_e;

    typedef logic [3:0] dtc_step_t;

endpackage

// >>> hw/dtc_core.sv
/*
 * Output driver calibration and on-die termination control of a DDR2
 * memory device, with an AHB-Lite register slave for setup and status.
 * Assumes command, data and termination pins arrive asynchronously to
 * hclk; self-refresh and bank-idle status come from logic on hclk.
 */
// Implementation choices: the register offsets and register access over AHB-Lite.
// Behaviour
// - Decode calibration field: exit, high, low, adjust, default
// - Drive modes set data, strobe, complement levels
// - Read strobe pair driven only if enabled
// - Decode four code bits into strength steps
// - One common strength for every data output
// - Strength saturates within sixteen steps
// - Default step is programmable, any value
// - Additive latency applies to adjust code
// - Code bits taken in fixed order
// - Drivers on and off after fixed delay
// - Termination on data, strobe, mask; complement conditional
// - Eight-bit: read strobe and mask termination rules
// - Sixteen-bit: both bytes terminated likewise
// - Termination forced off in self-refresh
// - Value field selects resistor; zero ignores pin
// - Clocked termination timing while loop runs
// - Direct termination timing while loop is off
// - Eight-bit read strobe disables mask function
`timescale 1ns/1ps
`include "dtc_defs.svh"

module dtc_core (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Command pins
    input  wire logic        cs_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic [1:0]  ba,
    input  wire logic [12:0] addr,
    input  wire logic        cke,
    input  wire logic        odt,
    // Data pins, input side
    input  wire logic [15:0] dq_in,
    // Device status on hclk
    input  wire logic        self_refresh,
    input  wire logic        banks_idle,
    // Data and strobe drivers
    output logic [15:0]      dq_out,
    output logic             dq_oe,
    output logic             dqs_out,
    output logic             dqs_oe,
    output logic             dqs_n_out,
    output logic             dqs_n_oe,
    output logic             rdqs_out,
    output logic             rdqs_oe,
    output logic             rdqs_n_out,
    output logic             rdqs_n_oe,
    // Driver strength
    output logic [3:0]       pu_step,
    output logic [3:0]       pd_step,
    // Termination
    output logic             term_dq,
    output logic             term_dqs,
    output logic             term_dqs_n,
    output logic             term_rdqs,
    output logic             term_rdqs_n,
    output logic             term_dm,
    output logic [1:0]       term_sel,
    output logic             term_async,
    output logic             dm_en
);

    // Pin synchronisers
    logic [20:0] pin_m;
    logic [20:0] pin_s;
    logic [15:0] dq_m;
    logic [15:0] dq_s;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_m <= 21'h1FFFFE;
            pin_s <= 21'h1FFFFE;
            dq_m  <= 16'h0000;
            dq_s  <= 16'h0000;
        end else begin
            pin_m <= {cs_n, ras_n, cas_n, we_n, ba, addr, cke, odt};
            pin_s <= pin_m;
            dq_m  <= dq_in;
            dq_s  <= dq_m;
        end
    end

    wire        s_cs_n  = pin_s[20];
    wire        s_ras_n = pin_s[19];
    wire        s_cas_n = pin_s[18];
    wire        s_we_n  = pin_s[17];
    wire [1:0]  s_ba    = pin_s[16:15];
    wire [12:0] s_addr  = pin_s[14:2];
    wire        s_cke   = pin_s[1];
    wire        s_odt   = pin_s[0];

    // Mode register writes
    wire mrs_any = !s_cs_n && !s_ras_n && !s_cas_n && !s_we_n;
    wire mrs0    = mrs_any && (s_ba == 2'b00);
    wire emrs1   = mrs_any && (s_ba == 2'b01);
    wire [2:0] cal_code = s_addr[`DTC_EMR_CAL_LSB +: 3];

    // Registers
    logic [12:0] mr;
    logic [12:0] emr;
    logic [31:0] ctrl;
    dtc_pkg::dtc_cal_e cal_mode;
    dtc_pkg::dtc_cal_e next_cal_mode;
    dtc_pkg::dtc_step_t pu;
    dtc_pkg::dtc_step_t pd;
    logic       drv_on;
    logic [2:0] oit_cnt;
    logic       adj_wait;
    logic [3:0] adj_cnt;
    logic       adj_cap;
    logic [2:0] bit_cnt;
    logic [3:0] code;
    logic       code_done;

    wire dtc_pkg::dtc_org_e org = dtc_pkg::dtc_org_e'(ctrl[`DTC_CTRL_ORG_LSB +: 2]);
    wire dtc_pkg::dtc_step_t def_step = ctrl[`DTC_CTRL_DEF_LSB +: 4];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mr  <= 13'h0000;
            emr <= 13'h0000;
        end else begin
            if (mrs0) begin
                mr <= s_addr;
            end
            if (emrs1) begin
                emr <= s_addr;
            end
        end
    end

    // Calibration mode decode
    always_comb begin
        next_cal_mode = cal_mode;
        if (emrs1) begin
            case (cal_code)
                `DTC_CAL_EXIT: next_cal_mode = dtc_pkg::DTC_CAL_OFF;
                `DTC_CAL_DRV1: next_cal_mode = dtc_pkg::DTC_CAL_HI;
                `DTC_CAL_DRV0: next_cal_mode = dtc_pkg::DTC_CAL_LO;
                `DTC_CAL_ADJ:  next_cal_mode = dtc_pkg::DTC_CAL_ADJ;
                `DTC_CAL_DEF:  next_cal_mode = dtc_pkg::DTC_CAL_OFF;
                default:       next_cal_mode = cal_mode;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_mode <= dtc_pkg::DTC_CAL_OFF;
        end else begin
            cal_mode <= next_cal_mode;
        end
    end

    // Driver turn-on and turn-off after fixed delay
    wire drive_mode = (cal_mode == dtc_pkg::DTC_CAL_HI) || (cal_mode == dtc_pkg::DTC_CAL_LO);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oit_cnt <= 3'h0;
            drv_on  <= 1'b0;
        end else if (drive_mode != drv_on) begin
            if (oit_cnt == 3'(`DTC_OIT_CYC - 1)) begin
                oit_cnt <= 3'h0;
                drv_on  <= drive_mode;
            end else begin
                oit_cnt <= oit_cnt + 3'h1;
            end
        end else begin
            oit_cnt <= 3'h0;
        end
    end

    // Adjust capture at write latency; count starts at two, so WL of two or more
    wire [3:0] wl = 4'(emr[`DTC_EMR_AL_LSB +: 3]) + 4'(mr[`DTC_MR_CL_LSB +: 3]) - 4'h1;
    wire adj_start = emrs1 && (cal_code == `DTC_CAL_ADJ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            adj_wait  <= 1'b0;
            adj_cnt   <= 4'h0;
            adj_cap   <= 1'b0;
            bit_cnt   <= 3'h0;
            code      <= 4'h0;
            code_done <= 1'b0;
        end else begin
            code_done <= 1'b0;
            if (adj_start) begin
                adj_wait <= 1'b1;
                adj_cnt  <= 4'h2;
                adj_cap  <= 1'b0;
            end else if (adj_wait) begin
                adj_cnt <= adj_cnt + 4'h1;
                if (adj_cnt >= wl) begin
                    adj_wait <= 1'b0;
                    adj_cap  <= 1'b1;
                    bit_cnt  <= 3'h0;
                end
            end
            if (adj_cap && !adj_start) begin
                code[bit_cnt[1:0]] <= dq_s[0];
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == `DTC_ADJ_LEN - 3'h1) begin
                    adj_cap   <= 1'b0;
                    code_done <= 1'b1;
                end
            end
        end
    end

    // Code decode: DT3 pull-up up, DT2 down, DT1 pull-down up, DT0 down
    wire code_ok = !(code[3] && code[2]) && !(code[1] && code[0]);
    wire pu_inc  = code_done && code_ok && code[3];
    wire pu_dec  = code_done && code_ok && code[2];
    wire pd_inc  = code_done && code_ok && code[1];
    wire pd_dec  = code_done && code_ok && code[0];

    // Saturating strength counters
    wire restore = emrs1 && (cal_code == `DTC_CAL_DEF);
    wire dtc_pkg::dtc_step_t next_pu = (pu_inc && pu != 4'hF) ? pu + 4'h1 :
                                       (pu_dec && pu != 4'h0) ? pu - 4'h1 : pu;
    wire dtc_pkg::dtc_step_t next_pd = (pd_inc && pd != 4'hF) ? pd + 4'h1 :
                                       (pd_dec && pd != 4'h0) ? pd - 4'h1 : pd;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pu <= 4'h8;
            pd <= 4'h8;
        end else if (restore) begin
            pu <= def_step;
            pd <= def_step;
        end else begin
            pu <= next_pu;
            pd <= next_pd;
        end
    end

    // Termination enables
    wire rtt_on   = emr[`DTC_EMR_RTT_HI] || emr[`DTC_EMR_RTT_LO];
    wire odt_ok   = rtt_on && !self_refresh;
    wire ndqs_en  = !emr[`DTC_EMR_NDQS];
    wire rdqs_en  = (org == dtc_pkg::DTC_ORG_X8) && emr[`DTC_EMR_RDQS];
    wire slow_pd  = !s_cke && (banks_idle || mr[`DTC_MR_SLOWPD]);
    logic odt_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            odt_q <= 1'b0;
        end else begin
            odt_q <= s_odt;
        end
    end

    // Clocked path adds one stage; loop-off path bypasses it
    wire odt_eff = (slow_pd ? s_odt : odt_q) && odt_ok;

    // Output registers
    wire hi = (cal_mode == dtc_pkg::DTC_CAL_HI);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dq_out      <= 16'h0000;
            dq_oe       <= 1'b0;
            dqs_out     <= 1'b0;
            dqs_oe      <= 1'b0;
            dqs_n_out   <= 1'b0;
            dqs_n_oe    <= 1'b0;
            rdqs_out    <= 1'b0;
            rdqs_oe     <= 1'b0;
            rdqs_n_out  <= 1'b0;
            rdqs_n_oe   <= 1'b0;
            pu_step     <= 4'h8;
            pd_step     <= 4'h8;
            term_dq     <= 1'b0;
            term_dqs    <= 1'b0;
            term_dqs_n  <= 1'b0;
            term_rdqs   <= 1'b0;
            term_rdqs_n <= 1'b0;
            term_dm     <= 1'b0;
            term_sel    <= 2'h0;
            term_async  <= 1'b0;
            dm_en       <= 1'b1;
        end else begin
            dq_out      <= {16{hi}};
            dq_oe       <= drv_on;
            dqs_out     <= hi;
            dqs_oe      <= drv_on;
            dqs_n_out   <= !hi;
            dqs_n_oe    <= drv_on && ndqs_en;
            rdqs_out    <= hi;
            rdqs_oe     <= drv_on && rdqs_en;
            rdqs_n_out  <= !hi;
            rdqs_n_oe   <= drv_on && rdqs_en && ndqs_en;
            pu_step     <= next_pu;
            pd_step     <= next_pd;
            term_dq     <= odt_eff;
            term_dqs    <= odt_eff;
            term_dqs_n  <= odt_eff && ndqs_en;
            term_rdqs   <= odt_eff && rdqs_en;
            term_rdqs_n <= odt_eff && rdqs_en && ndqs_en;
            term_dm     <= odt_eff && !rdqs_en;
            term_sel    <= {emr[`DTC_EMR_RTT_HI], emr[`DTC_EMR_RTT_LO]};
            term_async  <= slow_pd;
            dm_en       <= !rdqs_en;
        end
    end

    // AHB-Lite slave, zero wait states
    logic        wr_pend;
    logic [11:0] wr_addr;
    wire  sel_ok = hsel && hready && htrans[1];
    wire [31:0] stat = {19'h0, slow_pd, drv_on, 1'b0, cal_mode, pd, pu};
    wire [31:0] rd_mux = (haddr == `DTC_OFS_CTRL) ? ctrl :
                         (haddr == `DTC_OFS_STAT) ? stat :
                         (haddr == `DTC_OFS_EMR)  ? {19'h0, emr} :
                         (haddr == `DTC_OFS_MR)   ? {19'h0, mr} : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 12'h000;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            ctrl      <= `DTC_CTRL_RST;
        end else begin
            wr_pend <= sel_ok && hwrite;
            if (sel_ok) begin
                wr_addr <= haddr;
            end
            if (sel_ok && !hwrite) begin
                hrdata <= rd_mux;
            end
            if (wr_pend && wr_addr == `DTC_OFS_CTRL) begin
                ctrl <= {26'h0, hwdata[5:0]};
            end
        end
    end

endmodule

// >>> bench/dtc_monitor.sv
/* Checker of dtc_core: driver levels and timing, strength, termination.
   Assumes one hclk domain and sees only the top ports. */
`timescale 1ns/1ps
module dtc_monitor (
    // Clock, reset, pins
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        cs_n,
    input wire logic        cke,
    input wire logic        self_refresh,
    // Drivers and strength
    input wire logic [15:0] dq_out,
    input wire logic        dq_oe,
    input wire logic        dqs_out,
    input wire logic        dqs_n_out,
    input wire logic        dqs_n_oe,
    input wire logic [3:0]  pu_step,
    input wire logic [3:0]  pd_step,
    // Termination
    input wire logic        term_dq,
    input wire logic        term_dqs,
    input wire logic        term_dqs_n,
    input wire logic        term_rdqs,
    input wire logic        term_rdqs_n,
    input wire logic        term_dm,
    input wire logic [1:0]  term_sel,
    input wire logic        term_async
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Cycles since the last command on the pins
    logic [4:0] idle_cnt;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) idle_cnt <= 5'h00;
        else if (!cs_n) idle_cnt <= 5'h00;
        else if (idle_cnt != 5'h1F) idle_cnt <= idle_cnt + 5'h01;

    drive_delay_a: assert property ($changed(dq_oe) |-> idle_cnt inside {[5'h03:5'h08]})
        else $error("driver enable out of step with command");
    drive_level_a: assert property (dq_oe |-> dq_out == {16{dqs_out}} &&
        (!dqs_n_oe || dqs_n_out != dqs_out)) else $error("drive levels wrong");
    strength_hold_a: assert property (idle_cnt == 5'h1F |-> $stable({pu_step, pd_step}))
        else $error("strength moved without command");
    selfref_term_a: assert property (self_refresh [*4] |-> !term_dq && !term_dqs)
        else $error("termination on in self-refresh");
    cmpl_term_a: assert property (term_dqs_n |-> term_dqs && term_dq)
        else $error("complement strobe termination alone");
    rdqs_term_a: assert property (term_rdqs_n |-> term_rdqs && !term_dm)
        else $error("read strobe termination wrong");
    rtt_gate_a: assert property ((term_sel == 2'b00) [*4] |-> !term_dq)
        else $error("termination with value field off");
    sync_timing_a: assert property (cke [*5] |-> !term_async)
        else $error("direct timing with clock enabled");

    cover property ($rose(dq_oe));
    cover property ($rose(term_rdqs_n));
    cover property ($rose(term_async));
endmodule

bind dtc_core dtc_monitor mon (.hclk, .hresetn, .cs_n, .cke, .self_refresh, .dq_out, .dq_oe,
    .dqs_out, .dqs_n_out, .dqs_n_oe, .pu_step, .pd_step, .term_dq, .term_dqs, .term_dqs_n,
    .term_rdqs, .term_rdqs_n, .term_dm, .term_sel, .term_async);

// >>> bench/dtc_ctl_model.sv
/* Controller model: mode writes and adjust codes on the command and data pins.
   Assumes the bench calls one task at a time. */
`timescale 1ns/1ps
module dtc_ctl_model (
    // Clock
    input  wire logic        hclk,
    // Command and data pins
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic [1:0]       ba,
    output logic [12:0]      addr,
    output wire logic [15:0] dq_in
);
    logic drv;
    logic bitv;
    logic tog;
    initial begin
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        ba = 2'h0;
        addr = 13'h0000;
        {drv, bitv, tog} = 3'h0;
    end
    // Released data lines toggle every cycle
    always @(posedge hclk) tog <= ~tog;
    assign dq_in = drv ? {16{bitv}} : {16{tog}};

    task automatic mode_wr(input logic [1:0] b, input logic [12:0] a);
        @(posedge hclk);
        {cs_n, ras_n, cas_n, we_n} <= 4'h0;
        ba <= b;
        addr <= a;
        @(posedge hclk);
        {cs_n, ras_n, cas_n, we_n} <= 4'hF;
        repeat (12) @(posedge hclk);
    endtask

    // Adjust entry, code DT0 first at write latency, then exit
    task automatic adjust(input logic [12:0] a, input logic [3:0] c, input int wl);
        @(posedge hclk);
        {cs_n, ras_n, cas_n, we_n} <= 4'h0;
        ba <= 2'h1;
        addr <= a;
        @(posedge hclk);
        {cs_n, ras_n, cas_n, we_n} <= 4'hF;
        repeat (wl - 1) @(posedge hclk);
        for (int i = 3; i >= 0; i--) begin
            drv <= 1'b1;
            bitv <= c[i];
            @(posedge hclk);
        end
        drv <= 1'b0;
        repeat (12) @(posedge hclk);
        mode_wr(2'h1, a & 13'h1C7F);
    endtask
endmodule

// >>> bench/tb.sv
/* Bench of dtc_core: adjust code table, then limits, drive and termination.
   Assumes a zero-wait bus slave and the controller model on the pins. */
`timescale 1ns/1ps
module tb;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0]  htrans, ba, term_sel;
    logic [31:0] hwdata, hrdata, r;
    logic        cs_n, ras_n, cas_n, we_n, cke, odt, self_refresh, banks_idle;
    logic [12:0] addr, emr;
    logic [15:0] dq_in, dq_out;
    logic        dq_oe, dqs_out, dqs_oe, dqs_n_out, dqs_n_oe, rdqs_out, rdqs_oe;
    logic        rdqs_n_out, rdqs_n_oe, term_dq, term_dqs, term_dqs_n, term_rdqs;
    logic        term_rdqs_n, term_dm, term_async, dm_en;
    logic [3:0]  pu_step, pd_step;
    logic [23:0] xp;
    int          miscompares, n_checks;
    // Code DT0..DT3, then pull-up and pull-down expected from step 8
    logic [11:0] rows [12] = '{12'h088, 12'h198, 12'h278, 12'h489, 12'h887, 12'h599,
                               12'h679, 12'h997, 12'hA77, 12'h388, 12'hC88, 12'hF88};
    logic [12:0] dv [3] = '{13'h0880, 13'h0900, 13'h0080};

    dtc_core dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cs_n, .ras_n, .cas_n, .we_n, .ba,
        .addr, .cke, .odt, .dq_in, .self_refresh, .banks_idle, .dq_out, .dq_oe, .dqs_out,
        .dqs_oe, .dqs_n_out, .dqs_n_oe, .rdqs_out, .rdqs_oe, .rdqs_n_out, .rdqs_n_oe,
        .pu_step, .pd_step, .term_dq, .term_dqs, .term_dqs_n, .term_rdqs, .term_rdqs_n,
        .term_dm, .term_sel, .term_async, .dm_en
    );
    dtc_ctl_model ctl (.hclk, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq_in);

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    initial begin
        #1000000;
        miscompares++;
        $display("ERROR %0t watchdog expired", $time);
        results();
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic settle();
        repeat (8) @(posedge hclk);
    endtask
    task automatic tcase(input logic [31:0] c, input logic [12:0] e, input logic [8:0] x);
        bus(1'b1, 12'h000, c, r);
        ctl.mode_wr(2'h1, e);
        chk({term_sel, term_dq, term_dqs, term_dqs_n, term_rdqs, term_rdqs_n, term_dm, dm_en}, x);
    endtask

    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {cke, odt, self_refresh, banks_idle} = 4'h8;
        emr = 13'h000C;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        bus(1'b0, 12'h000, 32'h0, r);
        chk(r, 32'h0000_0020);
        bus(1'b1, 12'h004, 32'hFFFF_FFFF, r);
        bus(1'b0, 12'h004, 32'h0, r);
        chk(r[7:0], 8'h88);
        bus(1'b0, 12'h010, 32'h0, r);
        chk(r, 32'h0);
        chk({hresp, dq_oe, term_dq}, 3'h0);
        $display("reset test done");
        ctl.mode_wr(2'h0, 13'h0032);
        ctl.mode_wr(2'h1, emr);
        foreach (rows[i]) begin
            ctl.mode_wr(2'h1, emr | 13'h0380);
            ctl.mode_wr(2'h1, emr);
            ctl.adjust(emr | 13'h0200, rows[i][11:8], 3);
            chk({pu_step, pd_step}, rows[i][7:0]);
            $display("adjust code %h done", rows[i][11:8]);
        end
        bus(1'b1, 12'h000, 32'h0000_003C, r);
        ctl.mode_wr(2'h1, emr | 13'h0380);
        chk({pu_step, pd_step}, 8'hFF);
        ctl.mode_wr(2'h1, emr);
        ctl.adjust(emr | 13'h0200, 4'h5, 3);
        chk({pu_step, pd_step}, 8'hFF);
        bus(1'b1, 12'h000, 32'h0, r);
        ctl.mode_wr(2'h1, emr | 13'h0380);
        ctl.mode_wr(2'h1, emr);
        ctl.adjust(emr | 13'h0200, 4'hA, 3);
        chk({pu_step, pd_step}, 8'h00);
        $display("limit test done");
        bus(1'b1, 12'h000, 32'h0000_0021, r);
        foreach (dv[k]) begin
            ctl.mode_wr(2'h1, emr | dv[k]);
            xp = {1'b1, {17{dv[k][7]}}, ~dv[k][7], dv[k][11], dv[k][7], ~dv[k][7], dv[k][11],
                  1'b1};
            chk({dq_oe, dq_out, dqs_out, dqs_n_out, rdqs_oe, rdqs_out, rdqs_n_out, rdqs_n_oe,
                 dqs_n_oe}, xp);
            ctl.mode_wr(2'h1, emr | (dv[k] & 13'h0800));
            chk({dq_oe, dqs_oe, rdqs_oe}, 3'h0);
        end
        $display("drive test done");
        odt <= 1'b1;
        tcase(32'h21, 13'h0804, 9'h0FC);
        tcase(32'h21, 13'h0004, 9'h0F3);
        tcase(32'h21, 13'h0C04, 9'h0E8);
        tcase(32'h21, 13'h0800, 9'h000);
        tcase(32'h20, 13'h0404, 9'h0E3);
        tcase(32'h22, 13'h0044, 9'h1F3);
        self_refresh <= 1'b1;
        settle();
        chk({term_dq, term_dqs, term_dm}, 3'h0);
        self_refresh <= 1'b0;
        settle();
        chk({term_dq, term_dqs, term_dm}, 3'h7);
        odt <= 1'b0;
        settle();
        chk({term_dq, term_dqs, term_dm}, 3'h0);
        cke <= 1'b0;
        banks_idle <= 1'b0;
        settle();
        chk(term_async, 1'b0);
        banks_idle <= 1'b1;
        settle();
        chk(term_async, 1'b1);
        cke <= 1'b1;
        settle();
        chk(term_async, 1'b0);
        ctl.mode_wr(2'h0, 13'h1032);
        banks_idle <= 1'b0;
        cke <= 1'b0;
        settle();
        chk(term_async, 1'b1);
        odt <= 1'b1;
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        chk(term_dq, 1'b1);
        @(posedge hclk);
        odt <= 1'b0;
        cke <= 1'b1;
        settle();
        odt <= 1'b1;
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        chk(term_dq, 1'b0);
        @(negedge hclk);
        chk(term_dq, 1'b1);
        $display("termination test done");
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        chk({pu_step, pd_step, term_dq, term_async}, 10'h220);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        bus(1'b0, 12'h000, 32'h0, r);
        chk(r, 32'h0000_0020);
        $display("second reset test done");
        results();
    end
endmodule
